// *** hw/vmo_pkg.sv ***
package vmo_pkg;
   // register offsets
   localparam logic [7:0] VMO_OFS_SETUP = 8'h03;
   localparam logic [7:0] VMO_OFS_LEFT  = 8'h04;
   localparam logic [7:0] VMO_OFS_RIGHT = 8'h05;
   localparam logic [7:0] VMO_OFS_STAGE = 8'h06;
   localparam logic [7:0] VMO_OFS_SPARE = 8'h07;
   // reset values
   localparam logic [7:0] VMO_RST_SETUP = 8'h80;
   localparam logic [7:0] VMO_RST_LEFT  = 8'hcf;
   localparam logic [7:0] VMO_RST_RIGHT = 8'hcf;
   localparam logic [7:0] VMO_RST_STAGE = 8'h51;
   localparam logic [7:0] VMO_RST_SPARE = 8'h00;
   // field positions
   localparam int VMO_FADE_BIT   = 7;
   localparam int VMO_MUTE_R_BIT = 1;
   localparam int VMO_MUTE_L_BIT = 0;
   localparam int VMO_MONO_BIT   = 7;
   localparam int VMO_RATE_LO    = 4;
   localparam int VMO_GAIN_LO    = 2;
   localparam int VMO_SRC_BIT    = 1;
   // writable bits of the volume setup register
   localparam logic [7:0] VMO_SETUP_WMASK = 8'h83;
   localparam logic [1:0] VMO_GAIN_RSVD   = 2'h3;
   localparam logic [7:0] VMO_VOL_FLOOR   = 8'h07;
   // switching rate multiples of frame_clock, codes 7..0
   localparam logic [39:0] VMO_RATE_TABLE =
      {5'h18, 5'h14, 5'h10, 5'h0e, 5'h0c, 5'h0a, 5'h08, 5'h06};
   localparam int VMO_SAMPLE_W   = 24;
   localparam int VMO_DUTY_SHIFT = 9;
   localparam logic [6:0] VMO_I2C_ADDR = 7'h6c;
   typedef enum logic [2:0] {
      VMO_IDLE, VMO_ADDR, VMO_RECV, VMO_ACK, VMO_SEND, VMO_MACK
   } vmo_i2c_e;
endpackage

// *** hw/vmo_i2c_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmo_i2c_port import vmo_pkg::*; (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       ce,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [6:0] dev_addr,
   input  wire logic [7:0] reg_rdata,
   output logic            sda_oe,
   output logic            reg_wr,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   logic [1:0] scl_m;
   logic [1:0] sda_m;
   logic       scl_s;
   logic       sda_s;
   logic       scl_d;
   logic       sda_d;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   vmo_i2c_e   state;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic       rnw;
   logic       ptr_phase;

   // two-stage synchronisers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         scl_m <= 2'h3;
         sda_m <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else if (ce) begin
         scl_m <= {scl_m[0], scl_in};
         sda_m <= {sda_m[0], sda_in};
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
   assign scl_s = scl_m[1];
   assign sda_s = sda_m[1];
   assign rise  = scl_s & ~scl_d;
   assign fall  = ~scl_s & scl_d;
   assign start = scl_s & scl_d & sda_d & ~sda_s;
   assign stop  = scl_s & scl_d & ~sda_d & sda_s;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state     <= VMO_IDLE;
         cnt       <= 4'h0;
         shreg     <= 8'h00;
         tx        <= 8'h00;
         rnw       <= 1'b0;
         ptr_phase <= 1'b0;
         sda_oe    <= 1'b0;
         reg_wr    <= 1'b0;
         reg_addr  <= 8'h00;
         reg_wdata <= 8'h00;
      end else if (ce) begin
         reg_wr <= 1'b0;
         if (start) begin
            state     <= VMO_ADDR;
            cnt       <= 4'h0;
            ptr_phase <= 1'b1;
            sda_oe    <= 1'b0;
         end else if (stop) begin
            state  <= VMO_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               VMO_ADDR, VMO_RECV: begin
                  if (rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt   <= cnt + 4'h1;
                  end else if (fall && cnt == 4'h8) begin
                     cnt <= 4'h0;
                     if (state == VMO_ADDR) begin
                        if (shreg[7:1] == dev_addr) begin
                           rnw    <= shreg[0];
                           sda_oe <= 1'b1;
                           state  <= VMO_ACK;
                        end else begin
                           state <= VMO_IDLE;
                        end
                     end else begin
                        if (ptr_phase) begin
                           reg_addr  <= shreg;
                           ptr_phase <= 1'b0;
                        end else begin
                           reg_wr    <= 1'b1;
                           reg_wdata <= shreg;
                        end
                        sda_oe <= 1'b1;
                        state  <= VMO_ACK;
                     end
                  end
               end
               VMO_ACK: begin
                  if (fall) begin
                     cnt <= 4'h0;
                     if (rnw) begin
                        tx       <= reg_rdata;
                        sda_oe   <= ~reg_rdata[7];
                        reg_addr <= reg_addr + 8'h01;
                        state    <= VMO_SEND;
                     end else begin
                        sda_oe <= 1'b0;
                        if (!ptr_phase && reg_wr == 1'b0 && cnt == 4'h0) begin
                           reg_addr <= reg_addr;
                        end
                        state <= VMO_RECV;
                     end
                  end
               end
               VMO_SEND: begin
                  if (rise) begin
                     cnt <= cnt + 4'h1;
                  end else if (fall) begin
                     if (cnt == 4'h8) begin
                        sda_oe <= 1'b0;
                        state  <= VMO_MACK;
                     end else begin
                        tx     <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                     end
                  end
               end
               VMO_MACK: begin
                  if (rise) begin
                     state <= sda_s ? VMO_IDLE : VMO_ACK;
                  end
               end
               default: begin
                  state <= VMO_IDLE;
               end
            endcase
         end
         // auto-increment after each data write
         if (reg_wr) begin
            reg_addr <= reg_addr + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** hw/vmo_volume_output.sv ***
// Summary of operation
// - setup bit 7 set enables volume fading, clear disables it.
// - setup bit 1 set mutes the right channel.
// - setup bit 0 set mutes the left channel.
// - a muted output keeps running at half duty, period >> 1 high cycles (rounded down for an odd period).
// - volume codes are 8 bits, 0.5 dB steps, top code is +24 dB.
// - code 0xcf is unity gain and the reset value of both volumes.
// - code 0x07 is the quietest unmuted setting, -100 dB.
// - any volume code below 0x07 mutes that channel.
// - left volume at 0x04, right at 0x05, each only its own channel.
// - stage bit 7 picks stereo bridge (0) or parallel mono bridge (1).
// - stage bits 6:4 set switching rate 6..24 times frame_clock.
// - double-speed mode halves the switching rate for every code.
// - gain bits 3:2 select 19.2/22.6/25 dBV; code 11 never used.
// - in mono mode stage bit 1 picks left (1) or right (0) input.
// - double speed means 64-96 kHz frames, single 32-48 kHz.
`timescale 1ns/10ps
`default_nettype none
module vmo_volume_output import vmo_pkg::*; #(
   parameter int         CNT_W    = 16,
   parameter logic [6:0] DEV_ADDR = VMO_I2C_ADDR
) (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       ce,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       sclk_in,
   input  wire logic       sdin_in,
   input  wire logic       frame_clock,
   input  wire logic       double_speed,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            spk_a,
   output logic            spk_b,
   output logic            parallel_mono_bridge,
   output logic [1:0]      analog_gain,
   output logic [7:0]      gain_code_a,
   output logic [7:0]      gain_code_b,
   output logic            mute_a,
   output logic            mute_b
);
   if (CNT_W < 8 || CNT_W > 24) begin : g_bad_width
      $error("CNT_W must lie between 8 and 24");
   end

   logic [7:0]              volume_setup;
   logic [7:0]              left_volume;
   logic [7:0]              right_volume;
   logic [7:0]              output_stage_setup;
   logic [7:0]              spare_register;
   logic                    reg_wr;
   logic [7:0]              reg_addr;
   logic [7:0]              reg_wdata;
   logic [7:0]              reg_rdata;
   logic [2:0]              pin_m;
   logic [2:0]              pin_s;
   logic                    sclk_d;
   logic                    fc_d;
   logic                    sclk_rise;
   logic                    fc_rise;
   logic                    fc_fall;
   logic [VMO_SAMPLE_W-1:0] shreg;
   logic [VMO_SAMPLE_W-1:0] left_sample;
   logic [VMO_SAMPLE_W-1:0] right_sample;
   logic [7:0]              applied_l;
   logic [7:0]              applied_r;
   logic                    mute_l;
   logic                    mute_r;
   logic [VMO_SAMPLE_W-1:0] sample_a;
   logic [VMO_SAMPLE_W-1:0] sample_b;
   logic [CNT_W-1:0]        fc_cnt;
   logic [CNT_W-1:0]        div_q;
   logic [CNT_W-1:0]        div_r;
   logic [CNT_W:0]          div_t;
   logic [4:0]              div_n;
   logic                    div_busy;
   logic [4:0]              mult;
   logic [CNT_W-1:0]        period;
   logic [CNT_W-1:0]        pwm_cnt;
   logic [CNT_W-1:0]        duty_a;
   logic [CNT_W-1:0]        duty_b;

   function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                           input logic [7:0] s,
                                           input logic [7:0] l,
                                           input logic [7:0] r,
                                           input logic [7:0] g,
                                           input logic [7:0] p);
      case (addr)
         VMO_OFS_SETUP: read_reg = s;
         VMO_OFS_LEFT:  read_reg = l;
         VMO_OFS_RIGHT: read_reg = r;
         VMO_OFS_STAGE: read_reg = g;
         VMO_OFS_SPARE: read_reg = p;
         default:       read_reg = 8'h00;
      endcase
   endfunction

   // one step toward target when fading, else jump
   function automatic logic [7:0] step_toward(input logic [7:0] cur,
                                              input logic [7:0] tgt,
                                              input logic       fade);
      if (!fade || cur == tgt) begin
         step_toward = tgt;
      end else if (cur < tgt) begin
         step_toward = cur + 8'h01;
      end else begin
         step_toward = cur - 8'h01;
      end
   endfunction

   // half period plus sample scaled to a quarter period
   function automatic logic [CNT_W-1:0] calc_duty(input logic [7:0]       smp,
                                                  input logic [CNT_W-1:0] per,
                                                  input logic             mute);
      logic signed [CNT_W+8:0] prod;
      logic signed [CNT_W+8:0] sum;
      prod = $signed(smp) * $signed({1'b0, per});
      sum  = (prod >>> VMO_DUTY_SHIFT) + $signed({9'h000, per >> 1});
      if (mute) begin
         calc_duty = per >> 1;
      end else begin
         calc_duty = sum[CNT_W-1:0];
      end
   endfunction

   vmo_i2c_port u_port (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .ce        (ce),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .dev_addr  (DEV_ADDR),
      .reg_rdata (reg_rdata),
      .sda_oe    (sda_oe),
      .reg_wr    (reg_wr),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata)
   );
   assign sda_out   = 1'b0;
   assign reg_rdata = read_reg(reg_addr, volume_setup, left_volume, right_volume,
                               output_stage_setup, spare_register);

   // register file
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         volume_setup       <= VMO_RST_SETUP;
         left_volume        <= VMO_RST_LEFT;
         right_volume       <= VMO_RST_RIGHT;
         output_stage_setup <= VMO_RST_STAGE;
         spare_register     <= VMO_RST_SPARE;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            VMO_OFS_SETUP: begin
               volume_setup <= (volume_setup & ~VMO_SETUP_WMASK)
                             | (reg_wdata & VMO_SETUP_WMASK);
            end
            VMO_OFS_LEFT: begin
               left_volume <= reg_wdata;
            end
            VMO_OFS_RIGHT: begin
               right_volume <= reg_wdata;
            end
            VMO_OFS_STAGE: begin
               output_stage_setup[7:4] <= reg_wdata[7:4];
               output_stage_setup[1:0] <= reg_wdata[1:0];
               // reserved gain code is refused
               if (reg_wdata[VMO_GAIN_LO+1:VMO_GAIN_LO] != VMO_GAIN_RSVD) begin
                  output_stage_setup[3:2] <= reg_wdata[3:2];
               end
            end
            VMO_OFS_SPARE: begin
               spare_register <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // serial audio pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pin_m  <= 3'h0;
         pin_s  <= 3'h0;
         sclk_d <= 1'b0;
         fc_d   <= 1'b0;
      end else if (ce) begin
         pin_m  <= {frame_clock, sdin_in, sclk_in};
         pin_s  <= pin_m;
         sclk_d <= pin_s[0];
         fc_d   <= pin_s[2];
      end
   end
   assign sclk_rise = pin_s[0] & ~sclk_d;
   assign fc_rise   = pin_s[2] & ~fc_d;
   assign fc_fall   = ~pin_s[2] & fc_d;

   // sample capture
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shreg        <= '0;
         left_sample  <= '0;
         right_sample <= '0;
      end else if (ce) begin
         if (sclk_rise) begin
            shreg <= {shreg[VMO_SAMPLE_W-2:0], pin_s[1]};
         end
         if (fc_rise) begin
            left_sample <= shreg;
         end
         if (fc_fall) begin
            right_sample <= shreg;
         end
      end
   end

   // applied volume and mute, updated per frame
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         applied_l <= VMO_RST_LEFT;
         applied_r <= VMO_RST_RIGHT;
         mute_l    <= 1'b0;
         mute_r    <= 1'b0;
      end else if (ce && fc_rise) begin
         applied_l <= step_toward(applied_l, left_volume,
                                  volume_setup[VMO_FADE_BIT]);
         applied_r <= step_toward(applied_r, right_volume,
                                  volume_setup[VMO_FADE_BIT]);
         // mute follows the code applied in this same frame
         mute_l    <= volume_setup[VMO_MUTE_L_BIT]
                    | (step_toward(applied_l, left_volume,
                                   volume_setup[VMO_FADE_BIT]) < VMO_VOL_FLOOR);
         mute_r    <= volume_setup[VMO_MUTE_R_BIT]
                    | (step_toward(applied_r, right_volume,
                                   volume_setup[VMO_FADE_BIT]) < VMO_VOL_FLOOR);
      end
   end

   // channel routing for stereo or mono bridge
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sample_a    <= '0;
         sample_b    <= '0;
         gain_code_a <= VMO_RST_LEFT;
         gain_code_b <= VMO_RST_RIGHT;
         mute_a      <= 1'b0;
         mute_b      <= 1'b0;
      end else if (ce) begin
         if (output_stage_setup[VMO_MONO_BIT]) begin
            if (output_stage_setup[VMO_SRC_BIT]) begin
               sample_a    <= left_sample;
               gain_code_a <= applied_l;
               mute_a      <= mute_l;
            end else begin
               sample_a    <= right_sample;
               gain_code_a <= applied_r;
               mute_a      <= mute_r;
            end
            sample_b    <= output_stage_setup[VMO_SRC_BIT] ? left_sample : right_sample;
            gain_code_b <= output_stage_setup[VMO_SRC_BIT] ? applied_l : applied_r;
            mute_b      <= output_stage_setup[VMO_SRC_BIT] ? mute_l : mute_r;
         end else begin
            sample_a    <= left_sample;
            gain_code_a <= applied_l;
            mute_a      <= mute_l;
            sample_b    <= right_sample;
            gain_code_b <= applied_r;
            mute_b      <= mute_r;
         end
      end
   end
   assign parallel_mono_bridge = output_stage_setup[VMO_MONO_BIT];
   assign analog_gain          = output_stage_setup[VMO_GAIN_LO+1:VMO_GAIN_LO];

   // switching multiple, halved at double speed
   always_comb begin
      mult = VMO_RATE_TABLE[5*output_stage_setup[6:VMO_RATE_LO] +: 5];
      if (double_speed) begin
         mult = mult >> 1;
      end
   end
   assign div_t = {div_r, div_q[CNT_W-1]};

   // frame length and carrier period = frame / multiple
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         fc_cnt   <= '0;
         div_q    <= '0;
         div_r    <= '0;
         div_n    <= 5'h00;
         div_busy <= 1'b0;
         period   <= CNT_W'(2);
      end else if (ce) begin
         if (fc_rise) begin
            fc_cnt   <= '0;
            div_q    <= fc_cnt + 1'b1;
            div_r    <= '0;
            div_n    <= 5'(CNT_W);
            div_busy <= 1'b1;
         end else begin
            if (fc_cnt != '1) begin
               fc_cnt <= fc_cnt + 1'b1;
            end
            if (div_busy) begin
               if (div_t >= {{(CNT_W-4){1'b0}}, mult}) begin
                  div_r <= CNT_W'(div_t - {{(CNT_W-4){1'b0}}, mult});
                  div_q <= {div_q[CNT_W-2:0], 1'b1};
               end else begin
                  div_r <= div_t[CNT_W-1:0];
                  div_q <= {div_q[CNT_W-2:0], 1'b0};
               end
               div_n <= div_n - 5'h01;
               if (div_n == 5'h01) begin
                  div_busy <= 1'b0;
               end
            end else if (div_n == 5'h00 && div_q >= CNT_W'(2)) begin
               period <= div_q;
            end
         end
      end
   end

   // carrier and outputs
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pwm_cnt <= '0;
         duty_a  <= CNT_W'(1);
         duty_b  <= CNT_W'(1);
         spk_a   <= 1'b0;
         spk_b   <= 1'b0;
      end else if (ce) begin
         if (pwm_cnt >= period - 1'b1) begin
            pwm_cnt <= '0;
            duty_a  <= calc_duty(sample_a[VMO_SAMPLE_W-1 -: 8], period, mute_a);
            duty_b  <= calc_duty(sample_b[VMO_SAMPLE_W-1 -: 8], period, mute_b);
         end else begin
            pwm_cnt <= pwm_cnt + 1'b1;
         end
         spk_a <= pwm_cnt < duty_a;
         spk_b <= pwm_cnt < duty_b;
      end
   end
endmodule
`default_nettype wire

// *** sim/vmo_volume_output_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmo_volume_output_checker import vmo_pkg::*; (
   input wire logic       clk_sys,
   input wire logic       reset_n,
   input wire logic       frame_clock,
   input wire logic       sda_oe,
   input wire logic       parallel_mono_bridge,
   input wire logic [1:0] analog_gain,
   input wire logic [7:0] gain_code_a,
   input wire logic [7:0] gain_code_b,
   input wire logic       mute_a,
   input wire logic       mute_b
);
   logic       fc_q;
   logic [3:0] since;
   // cycles since the last frame rise, saturating
   always_ff @(posedge clk_sys) begin
      fc_q <= frame_clock;
      if (!reset_n) since <= 4'hf;
      else if (frame_clock && !fc_q) since <= 4'h0;
      else if (since != 4'hf) since <= since + 4'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_gain_legal; analog_gain != 2'h3; endproperty
   a_gain_legal: assert property (p_gain_legal) else $error("reserved gain applied");
   property p_rst_vals;
      $rose(reset_n) |-> gain_code_a == 8'hcf && gain_code_b == 8'hcf && !mute_a && !mute_b
         && !parallel_mono_bridge && analog_gain == 2'h0 && !sda_oe;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
   property p_floor_a; gain_code_a < 8'h07 |-> mute_a; endproperty
   a_floor_a: assert property (p_floor_a) else $error("left not muted");
   property p_floor_b; gain_code_b < 8'h07 |-> mute_b; endproperty
   a_floor_b: assert property (p_floor_b) else $error("right not muted");
   property p_frame_a; $changed(gain_code_a) || $changed(mute_a) |-> since <= 4'h8; endproperty
   a_frame_a: assert property (p_frame_a) else $error("left change off frame");
   property p_frame_b; $changed(gain_code_b) || $changed(mute_b) |-> since <= 4'h8; endproperty
   a_frame_b: assert property (p_frame_b) else $error("right change off frame");
   property p_mono_wr; $changed(parallel_mono_bridge) |-> ##[0:3] sda_oe; endproperty
   a_mono_wr: assert property (p_mono_wr) else $error("mode change without write");
   property p_gain_wr; $changed(analog_gain) |-> ##[0:3] sda_oe; endproperty
   a_gain_wr: assert property (p_gain_wr) else $error("gain change without write");
endmodule
bind vmo_volume_output vmo_volume_output_checker i_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .frame_clock(frame_clock), .sda_oe(sda_oe),
   .parallel_mono_bridge(parallel_mono_bridge), .analog_gain(analog_gain),
   .gain_code_a(gain_code_a), .gain_code_b(gain_code_b), .mute_a(mute_a), .mute_b(mute_b));
`default_nettype wire

// *** sim/vmo_audio_src.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmo_audio_src (
   output logic            sclk,
   output logic            sdin,
   output logic            frame,
   input  wire logic [23:0] left,
   input  wire logic [23:0] right
);
   // continuous frames of 64 bit clocks, left half while frame low
   initial begin
      sclk = 1'b0;
      sdin = 1'b0;
      frame = 1'b0;
      forever begin
         for (int h = 0; h < 2; h++) begin
            for (int i = 31; i >= 0; i--) begin
               sdin = (i > 23) ? i[0] : (h == 0 ? left[i] : right[i]);
               #200 sclk = 1'b1;
               #200 sclk = 1'b0;
               if (i == 0) frame = ~frame;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/vmo_volume_output_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module vmo_volume_output_tb_top import vmo_pkg::*; ;
   logic       clk_sys, reset_n, ce, scl, h_sda, ds;
   logic       sda_oe, spk_a, spk_b, mono, mute_a, mute_b, sclk, sdin, fclk;
   logic [1:0] again;
   logic [7:0] gca, gcb;
   logic [23:0] lsmp, rsmp;
   int         n_errors, compares;
   wire logic  sda_w = !(sda_oe || h_sda);
   vmo_volume_output i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda_w),
      .sclk_in(sclk), .sdin_in(sdin), .frame_clock(fclk), .double_speed(ds),
      .sda_out(), .sda_oe(sda_oe), .spk_a(spk_a), .spk_b(spk_b),
      .parallel_mono_bridge(mono), .analog_gain(again), .gain_code_a(gca),
      .gain_code_b(gcb), .mute_a(mute_a), .mute_b(mute_b));
   vmo_audio_src i_src (.sclk(sclk), .sdin(sdin), .frame(fclk), .left(lsmp), .right(rsmp));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic tk(input int n); repeat (n) @(posedge clk_sys); endtask
   task automatic fr(input int n); repeat (n) @(posedge fclk); tk(8); endtask
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic bio(input logic b, output logic s);
      h_sda <= !b; tk(8); scl <= 1'b1; tk(8); s = sda_w; scl <= 1'b0; tk(1);
   endtask
   task automatic byt(input logic [7:0] v, input logic ma, output logic [7:0] s, output logic a);
      for (int i = 7; i >= 0; i--) bio(v[i], s[i]);
      bio(ma, a);
   endtask
   task automatic sta;
      h_sda <= 1'b0; tk(8); scl <= 1'b1; tk(8); h_sda <= 1'b1; tk(8); scl <= 1'b0; tk(8);
   endtask
   task automatic sto;
      h_sda <= 1'b1; tk(8); scl <= 1'b1; tk(8); h_sda <= 1'b0; tk(8);
   endtask
   task automatic hdr(input logic [7:0] p);
      logic [7:0] s;
      logic       a;
      sta; byt({VMO_I2C_ADDR, 1'b0}, 1'b1, s, a); cmp("ack", 8'h00, {7'h00, a});
      byt(p, 1'b1, s, a); cmp("ack", 8'h00, {7'h00, a});
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] s;
      logic       a;
      hdr(p); byt(d, 1'b1, s, a); cmp("ack", 8'h00, {7'h00, a}); sto;
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] s;
      logic       a;
      hdr(p); sta; byt({VMO_I2C_ADDR, 1'b1}, 1'b1, s, a); cmp("ack", 8'h00, {7'h00, a});
      byt(8'hff, 1'b1, s, a); sto; cmp("rdata", e, s);
   endtask
   // high cycles and period of one carrier cycle
   task automatic meas(input logic sel, output int hi, output int per);
      logic lo;
      lo = 1'b0;
      hi = 1;
      @(posedge (sel ? spk_b : spk_a));
      for (per = 1; per < 999; per++) begin
         @(posedge clk_sys) #1;
         if ((sel ? spk_b : spk_a) !== 1'b1) lo = 1'b1;
         else if (lo) break;
         else hi++;
      end
      @(posedge clk_sys);
   endtask
   task automatic conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #5000000;
      n_errors++;
      conclude;
   end
   initial begin
      logic [7:0] rv [3:8] = '{8'h80, 8'hcf, 8'hcf, 8'h51, 8'h00, 8'h00};
      int         mt [8] = '{6, 8, 10, 12, 14, 16, 20, 24};
      int         hi, per;
      n_errors = 0; compares = 0; reset_n = 1'b0; ce = 1'b1; scl = 1'b1; h_sda = 1'b0;
      ds = 1'b0; lsmp = 24'h400000; rsmp = 24'hc00000;
      tk(2); reset_n <= 1'b1; tk(4);
      for (int i = 3; i < 9; i++) rd(8'(i), rv[i]);
      cmp("gca", 8'hcf, gca);
      cmp("mono", 8'h00, {7'h00, mono});
      $display("end reset values");
      wr(8'h03, 8'h83); rd(8'h03, 8'h83);
      wr(8'h03, 8'h03); fr(2);
      cmp("mutes", 8'h03, {6'h00, mute_b, mute_a});
      for (int d = 0; d < 2; d++) begin
         for (int c = 0; c < 8; c++) begin
            ds <= d[0]; wr(8'h06, {1'b0, c[2:0], 4'h1}); fr(2); meas(1'b0, hi, per);
            cmp("per", 8'(512 / (mt[c] >> d)), 8'(per));
            cmp("half", 8'((512 / (mt[c] >> d)) / 2), 8'(hi));
         end
      end
      $display("end rates");
      ds <= 1'b0; wr(8'h06, 8'h51); wr(8'h03, 8'h00); fr(2);
      meas(1'b0, hi, per); cmp("duty_a", 8'h14, 8'(hi));
      meas(1'b1, hi, per); cmp("duty_b", 8'h0c, 8'(hi));
      wr(8'h06, 8'hd3); fr(2); meas(1'b1, hi, per); cmp("mono_l", 8'h14, 8'(hi));
      cmp("mono", 8'h01, {7'h00, mono});
      wr(8'h06, 8'hd1); fr(2); meas(1'b0, hi, per); cmp("mono_r", 8'h0c, 8'(hi));
      $display("end outputs");
      for (int g = 0; g < 3; g++) begin
         wr(8'h06, {4'h5, g[1:0], 2'h1}); cmp("gain", 8'(g), {6'h00, again});
      end
      wr(8'h06, 8'h59); rd(8'h06, 8'h59);
      $display("end gain");
      wr(8'h06, 8'h51); wr(8'h04, 8'h06); fr(2);
      cmp("mute_a", 8'h01, {7'h00, mute_a});
      cmp("mute_b", 8'h00, {7'h00, mute_b});
      meas(1'b0, hi, per); cmp("floor", 8'h10, 8'(hi));
      wr(8'h04, 8'h07); fr(2); cmp("mute_a", 8'h00, {7'h00, mute_a});
      rd(8'h05, 8'hcf);
      $display("end volume");
      wr(8'h03, 8'h80); wr(8'h05, 8'hc7); fr(1);
      cmp("fade1", 8'hce, gcb);
      fr(1); cmp("fade2", 8'hcd, gcb);
      fr(8); cmp("fade_end", 8'hc7, gcb);
      wr(8'h03, 8'h00); wr(8'h05, 8'hcf); fr(1); cmp("jump", 8'hcf, gcb);
      $display("end fade");
      ce <= 1'b0; tk(20); ce <= 1'b1; reset_n <= 1'b0; tk(2); reset_n <= 1'b1; tk(4);
      cmp("gca", 8'hcf, gca); rd(8'h03, 8'h80);
      $display("end second reset");
      conclude;
   end
endmodule
`default_nettype wire
